// ===== core/euart_pkg.sv
// Purpose: Shared constants and types for the enhanced serial transceiver.
// Assumes: APB slave, 32-bit data, one word per register.
// Notes:   Offsets, field positions and reset values of the bus map are kept here.
package euart_pkg;
   localparam int          FIFO_DEPTH   = 15;
   localparam int          CNT_W        = 4;
   localparam int          BAUD_W       = 16;
   localparam int          OVERSAMPLE   = 16;
   localparam logic [3:0]  TICK_LAST    = 4'hf;
   localparam logic [3:0]  TICK_HALF    = 4'h7;
   localparam logic [2:0]  WLEN_BASE    = 3'h4;
   localparam int          ADDR_W       = 8;
   localparam logic [7:0]  OFS_LCR      = 8'h00;
   localparam logic [7:0]  OFS_DATA     = 8'h04;
   localparam logic [7:0]  OFS_BAUD     = 8'h08;
   localparam logic [7:0]  OFS_TRIG     = 8'h0c;
   localparam logic [7:0]  OFS_STAT     = 8'h10;
   localparam logic [7:0]  LCR_RST      = 8'h00;
   localparam logic [15:0] BAUD_RST     = 16'h0001;
   localparam logic [3:0]  TX_LVL_RST   = 4'h1;
   localparam logic [3:0]  RX_LVL_RST   = 4'h1;
   localparam int          LCR_EN       = 7;
   localparam int          LCR_SB       = 6;
   localparam int          LCR_WLS_LO   = 4;
   localparam int          LCR_OP       = 2;
   localparam int          LCR_PE       = 1;
   localparam int          LCR_SP       = 0;
   localparam int          TRIG_TX_LO   = 0;
   localparam int          TRIG_RX_LO   = 8;
   localparam int          STAT_RX_LO   = 4;
   localparam int          STAT_TXREQ   = 8;
   localparam int          STAT_RXREQ   = 9;
   localparam int          STAT_BUSY    = 10;
   localparam int          STAT_PARITY_ERROR_FLAG    = 11;

   typedef struct packed {
      logic       serial_enable;
      logic       stop_bit_select;
      logic [1:0] word_length_select;
      logic       odd_parity_select;
      logic       parity_enable;
      logic       stick_parity_select;
   } line_ctrl_type;

   typedef struct packed {
      logic       parity_error_flag;
      logic [7:0] data;
   } rx_word_type;
endpackage

// ===== core/euart_fifo.sv
// Purpose: Synchronous FIFO with valid/ready on both sides.
// Assumes: Single clock; clear empties it in one cycle.
// Notes:   Count saturates at DEPTH; full refuses writes, empty refuses reads.
module euart_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 15,
   parameter int CNT_W = 4
) (
   input  wire logic             mclk,
   input  wire logic             rst_n,
   input  wire logic             clr,
   input  wire logic             wr_valid,
   output      logic             wr_ready,
   input  wire logic [WIDTH-1:0] wr_data,
   output      logic             rd_valid,
   input  wire logic             rd_ready,
   output      logic [WIDTH-1:0] rd_data,
   output      logic [CNT_W-1:0] count
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [CNT_W-1:0] wp_r;
   logic [CNT_W-1:0] rp_r;
   logic [CNT_W-1:0] cnt_r;
   logic             push;
   logic             pop;

   assign wr_ready = (cnt_r != CNT_W'(DEPTH));
   assign rd_valid = (cnt_r != '0);
   assign push     = wr_valid & wr_ready;
   assign pop      = rd_valid & rd_ready;
   assign rd_data  = mem[rp_r];
   assign count    = cnt_r;

   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wp_r] <= wr_data;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else if (clr) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wp_r <= (wp_r == CNT_W'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= (rp_r == CNT_W'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
         end
         if (push && !pop) begin
            cnt_r <= cnt_r + 1'b1;
         end else if (pop && !push) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end
endmodule // euart_fifo

// ===== core/euart.sv
// Purpose: Enhanced serial transceiver with FIFOs and programmable framing.
// Assumes: APB3 slave on mclk; rxd is asynchronous and is synchronised.
// Notes:   One wait state on every APB access; overflow writes are dropped.
module euart
   import euart_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
) (
   input  wire logic              mclk,
   input  wire logic              rst_n,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output      logic [31:0]       prdata,
   output      logic              pready,
   output      logic              pslverr,
   input  wire logic              rxd,
   output      logic              txd,
   output      logic              tx_fifo_req,
   output      logic              rx_fifo_req
);
   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_type;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_type;

   line_ctrl_type     lcr_r;
   logic [BAUD_W-1:0] baud_r;
   logic [BAUD_W-1:0] div_cnt_r;
   logic              tick_r;
   logic [3:0]        tx_lvl_r;
   logic [3:0]        rx_lvl_r;
   logic [31:0]       prdata_r;
   logic              pready_r;
   logic              pslverr_r;
   logic              access;
   logic              xfer;
   logic              mapped;
   logic              tx_push;
   logic              rx_pop;
   logic              tx_wr_ready;
   logic              tx_rd_valid;
   logic              tx_rd_ready;
   logic [7:0]        tx_rd_data;
   logic [CNT_W-1:0]  tx_cnt;
   logic              rx_wr_valid;
   rx_word_type       rx_wr_data;
   logic              rx_rd_valid;
   rx_word_type       rx_rd_data;
   logic [CNT_W-1:0]  rx_cnt;
   logic [2:0]        last_bit;
   logic              rx_meta_r;
   logic              rx_sync_r;
   tx_state_type      tx_state_r;
   logic [3:0]        tx_tick_r;
   logic [2:0]        tx_bit_r;
   logic [7:0]        tx_sh_r;
   logic              tx_par_r;
   logic              txd_r;
   rx_state_type      rx_state_r;
   logic [3:0]        rx_tick_r;
   logic [2:0]        rx_bit_r;
   logic [7:0]        rx_sh_r;
   logic              rx_parity_error_flag_r;
   logic              rx_push_r;
   logic              tx_req_r;
   logic              rx_req_r;

   assign access   = psel & penable & ~pready_r;
   assign xfer     = psel & penable & pready_r;
   assign mapped   = (paddr == OFS_LCR) | (paddr == OFS_DATA) | (paddr == OFS_BAUD) |
                     (paddr == OFS_TRIG) | (paddr == OFS_STAT);
   assign tx_push  = xfer & pwrite & (paddr == OFS_DATA);
   assign rx_pop   = xfer & ~pwrite & (paddr == OFS_DATA);
   assign last_bit = {1'b0, lcr_r.word_length_select} + WLEN_BASE;

   assign prdata      = prdata_r;
   assign pready      = pready_r;
   assign pslverr     = pslverr_r;
   assign txd         = txd_r;
   assign tx_fifo_req = tx_req_r;
   assign rx_fifo_req = rx_req_r;

   // Both queues sit between the bus and the shifters.
   euart_fifo #(
      .WIDTH (8),
      .DEPTH (DEPTH),
      .CNT_W (CNT_W)
   ) u_tx_fifo (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .clr      (1'b0),
      .wr_valid (tx_push),
      .wr_ready (tx_wr_ready),
      .wr_data  (pwdata[7:0]),
      .rd_valid (tx_rd_valid),
      .rd_ready (tx_rd_ready),
      .rd_data  (tx_rd_data),
      .count    (tx_cnt)
   );

   euart_fifo #(
      .WIDTH ($bits(rx_word_type)),
      .DEPTH (DEPTH),
      .CNT_W (CNT_W)
   ) u_rx_fifo (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .clr      (1'b0),
      .wr_valid (rx_wr_valid),
      .wr_ready (),
      .wr_data  (rx_wr_data),
      .rd_valid (rx_rd_valid),
      .rd_ready (rx_pop),
      .rd_data  (rx_rd_data),
      .count    (rx_cnt)
   );

   // APB handshake: one wait state lets read data come from a flop.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         pready_r  <= access;
         pslverr_r <= access & ~mapped;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         prdata_r <= '0;
      end else if (access && !pwrite) begin
         prdata_r <= '0;
         unique case (paddr)
            OFS_LCR: begin
               prdata_r[LCR_EN]                 <= lcr_r.serial_enable;
               prdata_r[LCR_SB]                 <= lcr_r.stop_bit_select;
               prdata_r[LCR_WLS_LO +: 2]        <= lcr_r.word_length_select;
               prdata_r[LCR_OP]                 <= lcr_r.odd_parity_select;
               prdata_r[LCR_PE]                 <= rx_rd_valid &
                                                   rx_rd_data.parity_error_flag;
               prdata_r[LCR_SP]                 <= lcr_r.stick_parity_select;
            end
            OFS_DATA: prdata_r[7:0] <= rx_rd_data.data;
            OFS_BAUD: prdata_r[BAUD_W-1:0] <= baud_r;
            OFS_TRIG: begin
               prdata_r[TRIG_TX_LO +: 4] <= tx_lvl_r;
               prdata_r[TRIG_RX_LO +: 4] <= rx_lvl_r;
            end
            OFS_STAT: begin
               prdata_r[CNT_W-1:0]             <= tx_cnt;
               prdata_r[STAT_RX_LO +: CNT_W]   <= rx_cnt;
               prdata_r[STAT_TXREQ]            <= tx_req_r;
               prdata_r[STAT_RXREQ]            <= rx_req_r;
               prdata_r[STAT_BUSY]             <= (tx_state_r != TX_IDLE);
               prdata_r[STAT_PARITY_ERROR_FLAG]             <= rx_rd_valid & rx_rd_data.parity_error_flag;
            end
            default: prdata_r <= '0;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         lcr_r <= line_ctrl_type'(LCR_RST);
      end else if (xfer && pwrite && paddr == OFS_LCR) begin
         lcr_r.serial_enable       <= pwdata[LCR_EN];
         lcr_r.stop_bit_select     <= pwdata[LCR_SB];
         lcr_r.word_length_select  <= pwdata[LCR_WLS_LO +: 2];
         lcr_r.odd_parity_select   <= pwdata[LCR_OP];
         lcr_r.parity_enable       <= pwdata[LCR_PE];
         lcr_r.stick_parity_select <= pwdata[LCR_SP];
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         baud_r   <= BAUD_RST;
         tx_lvl_r <= TX_LVL_RST;
         rx_lvl_r <= RX_LVL_RST;
      end else if (xfer && pwrite) begin
         if (paddr == OFS_BAUD) begin
            baud_r <= pwdata[BAUD_W-1:0];
         end
         if (paddr == OFS_TRIG) begin
            tx_lvl_r <= pwdata[TRIG_TX_LO +: 4];
            rx_lvl_r <= pwdata[TRIG_RX_LO +: 4];
         end
      end
   end

   // Private divider; a divisor of zero behaves as one so the tick never stops.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt_r <= '0;
         tick_r    <= 1'b0;
      end else if (div_cnt_r + 1'b1 >= baud_r) begin
         div_cnt_r <= '0;
         tick_r    <= 1'b1;
      end else begin
         div_cnt_r <= div_cnt_r + 1'b1;
         tick_r    <= 1'b0;
      end
   end

   // Thresholds: transmit asks when its level or fewer remain, receive when its level is met and the queue is not empty.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tx_req_r <= 1'b0;
         rx_req_r <= 1'b0;
      end else begin
         tx_req_r <= (tx_cnt <= tx_lvl_r);
         rx_req_r <= (rx_cnt >= rx_lvl_r) && (rx_cnt != '0);
      end
   end

   assign tx_rd_ready = lcr_r.serial_enable & (tx_state_r == TX_IDLE) & tick_r;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tx_state_r <= TX_IDLE;
         tx_tick_r  <= '0;
         tx_bit_r   <= '0;
         tx_sh_r    <= '0;
         tx_par_r   <= 1'b0;
         txd_r      <= 1'b1;
      end else if (tick_r) begin
         tx_tick_r <= tx_tick_r + 1'b1;
         unique case (tx_state_r)
            TX_IDLE: begin
               txd_r     <= 1'b1;
               tx_tick_r <= '0;
               if (tx_rd_ready && tx_rd_valid) begin
                  tx_sh_r    <= tx_rd_data;
                  tx_par_r   <= lcr_r.stick_parity_select ? 1'b1 :
                                (^(tx_rd_data & (8'hff >> (2'h3 - lcr_r.word_length_select))))
                                ^ lcr_r.odd_parity_select;
                  txd_r      <= 1'b0;
                  tx_state_r <= TX_START;
               end
            end
            TX_START: begin
               if (tx_tick_r == TICK_LAST) begin
                  tx_bit_r   <= '0;
                  txd_r      <= tx_sh_r[0];
                  tx_state_r <= TX_DATA;
               end
            end
            TX_DATA: begin
               if (tx_tick_r == TICK_LAST) begin
                  tx_bit_r <= tx_bit_r + 1'b1;
                  txd_r    <= tx_sh_r[tx_bit_r + 1'b1];
                  if (tx_bit_r == last_bit) begin
                     tx_bit_r   <= '0;
                     txd_r      <= lcr_r.parity_enable ? tx_par_r : 1'b1;
                     tx_state_r <= lcr_r.parity_enable ? TX_PAR : TX_STOP;
                  end
               end
            end
            TX_PAR: begin
               if (tx_tick_r == TICK_LAST) begin
                  txd_r      <= 1'b1;
                  tx_state_r <= TX_STOP;
               end
            end
            TX_STOP: begin
               if (tx_tick_r == TICK_LAST) begin
                  tx_bit_r <= tx_bit_r + 1'b1;
                  if (tx_bit_r == {2'b00, lcr_r.stop_bit_select}) begin
                     tx_state_r <= TX_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // The first flop only feeds the second; everything else reads rx_sync_r.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rx_meta_r <= 1'b1;
         rx_sync_r <= 1'b1;
      end else begin
         rx_meta_r <= rxd;
         rx_sync_r <= rx_meta_r;
      end
   end

   assign rx_wr_valid = rx_push_r;
   assign rx_wr_data  = '{parity_error_flag: rx_parity_error_flag_r, data: rx_sh_r};

   // A byte arriving with the receive queue full is lost.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rx_state_r <= RX_IDLE;
         rx_tick_r  <= '0;
         rx_bit_r   <= '0;
         rx_sh_r    <= '0;
         rx_parity_error_flag_r  <= 1'b0;
         rx_push_r  <= 1'b0;
      end else begin
         rx_push_r <= 1'b0;
         if (tick_r) begin
            rx_tick_r <= rx_tick_r + 1'b1;
            unique case (rx_state_r)
               RX_IDLE: begin
                  rx_tick_r <= '0;
                  if (lcr_r.serial_enable && !rx_sync_r) begin
                     rx_state_r <= RX_START;
                  end
               end
               RX_START: begin
                  if (rx_tick_r == TICK_HALF) begin
                     rx_tick_r  <= '0;
                     rx_bit_r   <= '0;
                     rx_sh_r    <= '0;
                     rx_state_r <= rx_sync_r ? RX_IDLE : RX_DATA;
                  end
               end
               RX_DATA: begin
                  if (rx_tick_r == TICK_LAST) begin
                     rx_sh_r[rx_bit_r] <= rx_sync_r;
                     rx_bit_r          <= rx_bit_r + 1'b1;
                     if (rx_bit_r == last_bit) begin
                        rx_state_r <= lcr_r.parity_enable ? RX_PAR : RX_STOP;
                     end
                  end
               end
               RX_PAR: begin
                  if (rx_tick_r == TICK_LAST) begin
                     rx_parity_error_flag_r  <= rx_sync_r != (lcr_r.stick_parity_select ? 1'b1 :
                                   (^rx_sh_r) ^ lcr_r.odd_parity_select);
                     rx_state_r <= RX_STOP;
                  end
               end
               RX_STOP: begin
                  if (rx_tick_r == TICK_LAST) begin
                     rx_push_r  <= 1'b1;
                     rx_state_r <= RX_IDLE;
                  end
               end
            endcase
         end
         if (rx_push_r) begin
            rx_parity_error_flag_r <= 1'b0;
         end
      end
   end
endmodule // euart

// ===== tb/euart_chk.sv
// Purpose: Port checker for euart, bound to the top module.
// Assumes: Divisor and line control stay fixed while a frame is on txd.
// Notes:   Keeps its own copies of line control and bit length.
module euart_chk
   import euart_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic              mclk,
   input wire logic              rst_n,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic              rxd,
   input wire logic              txd,
   input wire logic              tx_fifo_req,
   input wire logic              rx_fifo_req
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   logic [7:0] lcr_r;
   int         bit_r;
   int         low_r;
   int         low_max;
   logic       acc;
   assign acc     = psel & penable & pready;
   assign low_max = (6 + int'(lcr_r[5:4]) + int'(lcr_r[1])) * bit_r;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         lcr_r <= LCR_RST;
         bit_r <= 16;
      end else if (acc && pwrite && paddr == OFS_LCR) begin
         lcr_r <= pwdata[7:0];
      end else if (acc && pwrite && paddr == OFS_BAUD) begin
         bit_r <= 16 * ((pwdata[15:0] == 16'h0000) ? 1 : int'(pwdata[15:0]));
      end
   end
   // The low run of txd is what the frame timing is judged on.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         low_r <= 0;
      else if (!txd)
         low_r <= low_r + 1;
      else
         low_r <= 0;
   end
   sequence s_waiting;
      psel && penable && !pready;
   endsequence
   sequence s_low_end;
      $rose(txd);
   endsequence
   property p_wait;
      s_waiting |=> pready;
   endproperty
   property p_pulse;
      pready |=> !pready;
   endproperty
   property p_err;
      pready |-> pslverr == (paddr > OFS_STAT || paddr[1:0] != 2'h0);
   endproperty
   property p_stat;
      acc && !pwrite && paddr == OFS_STAT |->
         prdata[3:0] <= DEPTH && prdata[7:4] <= DEPTH && prdata[31:12] == 20'h00000;
   endproperty
   property p_trig;
      acc && pwrite && paddr == OFS_TRIG && pwdata[3:0] == 4'hf |-> ##[1:3] tx_fifo_req;
   endproperty
   property p_bit;
      s_low_end |-> (low_r % bit_r) == 0;
   endproperty
   property p_wlen;
      s_low_end |-> low_r <= low_max;
   endproperty
   property p_lcr;
      acc && !pwrite && paddr == OFS_LCR |-> prdata[31:8] == 24'h000000
         && prdata[7:4] == lcr_r[7:4] && prdata[3] == 1'b0 && prdata[0] == lcr_r[0];
   endproperty
   a_wait: assert property (p_wait)
      else $error("no answer one cycle after access");
   a_pulse: assert property (p_pulse)
      else $error("pready longer than one cycle");
   a_err: assert property (p_err)
      else $error("pslverr wrong for address");
   a_stat: assert property (p_stat)
      else $error("fifo count beyond depth");
   a_trig: assert property (p_trig)
      else $error("tx request missing at full threshold");
   a_bit: assert property (p_bit)
      else $error("low run not whole bit times");
   a_wlen: assert property (p_wlen)
      else $error("low run longer than a frame allows");
   a_lcr: assert property (p_lcr)
      else $error("line control read back wrong");
endmodule // euart_chk

bind euart euart_chk #(.DEPTH(DEPTH)) u_chk (.mclk(mclk), .rst_n(rst_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .tx_fifo_req(tx_fifo_req),
   .rx_fifo_req(rx_fifo_req));

// ===== tb/euart_peer.sv
// Purpose: Remote serial node: sends frames on rxd, samples frames on txd.
// Assumes: Bit length in mclk cycles is given by the caller.
// Notes:   Line idles high as the pull-up would leave it.
module euart_peer (
   input  wire logic mclk,
   input  wire logic txd,
   output logic      rxd
);
   timeunit 1ns;
   timeprecision 1ps;
   initial rxd = 1'b1;
   task automatic hold_bit(input logic v, input int bl);
      @(posedge mclk);
      rxd <= v;
      repeat (bl - 1) @(posedge mclk);
   endtask
   task automatic send(input logic [7:0] d, input int wl, input logic pe, input logic par,
                       input int bl);
      hold_bit(1'b0, bl);
      for (int k = 0; k < wl; k++) hold_bit(d[k], bl);
      if (pe) hold_bit(par, bl);
      hold_bit(1'b1, bl);
   endtask
   // Samples sixteen bit centres from a start bit; unknown if none comes.
   task automatic recv(input int bl, output logic [15:0] s);
      int k;
      s = 'x;
      k = 0;
      while (txd !== 1'b0 && k < 20000) begin
         @(posedge mclk);
         k++;
      end
      if (txd === 1'b0) begin
         repeat (bl / 2) @(posedge mclk);
         for (int i = 0; i < 16; i++) begin
            s[i] = txd;
            repeat (bl) @(posedge mclk);
         end
      end
   endtask
endmodule // euart_peer

// ===== tb/euart_test.sv
// Purpose: Self-checking bench for euart over APB and the serial pins.
// Assumes: Divisor changed only while the transmitter is idle.
// Notes:   Back-to-back frames expose the stop-bit count.
module euart_test;
   import euart_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic              mclk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic              rxd, txd, tx_fifo_req, rx_fifo_req, last_err;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata, prdata;
   int                n_fail, n_tests;
   euart #(.DEPTH(FIFO_DEPTH)) dut (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .rxd, .txd, .tx_fifo_req, .rx_fifo_req);
   euart_peer peer (.mclk, .txd, .rxd);
   task automatic give_verdict;
      $display("checks %0d fails %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int k;
      @(posedge mclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) begin
         n_fail++;
         give_verdict;
      end
      q = prdata;
      last_err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      apb(1'b1, a, d, q);
   endtask
   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      apb(1'b0, a, 32'h0, q);
      check(nm, q, e);
   endtask
   // Polling keeps the bench free of any assumed drain time.
   task automatic wait_idle;
      logic [31:0] q;
      int k;
      k = 0;
      do begin
         apb(1'b0, OFS_STAT, 32'h0, q);
         k++;
      end while ((q[3:0] !== 4'h0 || q[STAT_BUSY] !== 1'b0) && k < 2000);
      if (k >= 2000) begin
         n_fail++;
         give_verdict;
      end
   endtask
   function automatic logic par(logic [7:0] d, int wl, logic op, logic sp);
      return sp ? 1'b1 : (^(d & ((8'h01 << wl) - 8'h01)) ^ op);
   endfunction
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   initial begin
      logic [15:0] s, e, m;
      logic [7:0]  lc;
      int          d, bl, wl, p;
      logic        sb, pe, op, sp;
      {rst_n, psel, penable, pwrite, paddr, pwdata, n_fail, n_tests} = '0;
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      rdc("lcr", OFS_LCR, 32'h0);
      rdc("baud", OFS_BAUD, 32'h1);
      rdc("trig", OFS_TRIG, 32'h101);
      rdc("stat", OFS_STAT, 32'h100);
      rdc("hole", 8'h14, 32'h0);
      check("slverr", last_err, 32'h1);
      $display("test registers done");
      for (int i = 0; i < 8; i++) begin
         d = i % 3;
         bl = 16 * ((d == 0) ? 1 : d);
         wl = 5 + i % 4;
         sb = i / 4;
         pe = (i % 3 != 0);
         op = i[0];
         sp = (i == 5);
         lc = {1'b0, sb, 2'(wl - 5), 1'b0, op, pe, sp};
         wr(OFS_BAUD, d);
         wr(OFS_LCR, lc);
         wr(OFS_DATA, 32'ha5);
         wr(OFS_DATA, 32'h3c);
         fork
            peer.recv(bl, s);
            wr(OFS_LCR, lc | 8'h80);
         join
         e = '0;
         p = 1;
         for (int k = 0; k < wl; k++) begin
            e[p] = 8'ha5 >> k;
            p++;
         end
         if (pe) begin
            e[p] = par(8'ha5, wl, op, sp);
            p++;
         end
         e[p] = 1'b1;
         p++;
         if (sb) begin
            e[p] = 1'b1;
            p++;
         end
         m = (16'h0001 << (p + 1)) - 16'h0001;
         check("frame", s & m, e);
         wait_idle;
         wr(OFS_LCR, lc);
      end
      $display("test framing done");
      wr(OFS_BAUD, 32'h1);
      wr(OFS_LCR, 32'hb2);
      peer.send(8'h5a, 8, 1'b1, ^8'h5a, 16);
      peer.send(8'hc3, 8, 1'b1, ~^8'hc3, 16);
      rdc("stat2", OFS_STAT, 32'h320);
      rdc("perr0", OFS_LCR, 32'hb0);
      rdc("rx0", OFS_DATA, 32'h5a);
      rdc("perr1", OFS_LCR, 32'hb2);
      rdc("rx1", OFS_DATA, 32'hc3);
      rdc("perr2", OFS_LCR, 32'hb0);
      $display("test parity done");
      wr(OFS_LCR, 32'h30);
      for (int k = 0; k < 16; k++) wr(OFS_DATA, k);
      rdc("txfull", OFS_STAT, 32'h00f);
      check("txreq0", tx_fifo_req, 32'h0);
      wr(OFS_TRIG, 32'hf0f);
      rdc("trig2", OFS_TRIG, 32'hf0f);
      check("txreq1", tx_fifo_req, 32'h1);
      wr(OFS_LCR, 32'hb0);
      fork
         wait_idle;
         for (int k = 0; k < 16; k++) peer.send(k, 8, 1'b0, 1'b0, 16);
      join
      rdc("rxfull", OFS_STAT, 32'h3f0);
      check("rxreq1", rx_fifo_req, 32'h1);
      for (int k = 0; k < 15; k++) rdc("rxdata", OFS_DATA, k);
      rdc("empty", OFS_STAT, 32'h100);
      check("rxreq0", rx_fifo_req, 32'h0);
      $display("test fifos done");
      give_verdict;
   end
endmodule // euart_test
